// ===== rtl/rscr_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 receiver state control register bank.
 Assumes a byte-wide register port with 7-bit addresses.
*/
`ifndef RSCR_REGS_SVH
`define RSCR_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define RSCR_OFS_FUNC        7'h46
`define RSCR_OFS_OPCTL       7'h47
`define RSCR_OFS_SWRST       7'h4f

// ----------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------
`define RSCR_BIT_TIMER_HALT  6
`define RSCR_BIT_TEST_EN     5
`define RSCR_BIT_FAST_SER    2
`define RSCR_FUNC_MASK       8'h64
`define RSCR_FUNC_RESET      8'h00
`define RSCR_SWRST_KEY       8'hff
`define RSCR_CMD_NVM         5'h01
`define RSCR_CMD_STBY        5'h02
`define RSCR_CMD_TUNE        5'h04
`define RSCR_CMD_RX          5'h08
`define RSCR_CMD_SLEEP       5'h10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSCR_CLK_NS          40
`define RSCR_SETTLE_NS       4000
`define RSCR_SETTLE_CYC      ((`RSCR_SETTLE_NS + `RSCR_CLK_NS - 1) / `RSCR_CLK_NS)
`define RSCR_SWRST_HOLD_MS   10
`define RSCR_PUP_CYC_DEF     64

`endif

// ===== rtl/rscr_pkg.sv
/*
 Types of the receiver state control register bank.
 Assumes the offsets and counts in rscr_regs.svh.
*/
package rscr_pkg;
   // Operating state codes as read back in the top three bits
   typedef enum logic [2:0] {
      RSCR_ST_PUP   = 3'b000,
      RSCR_ST_SLEEP = 3'b001,
      RSCR_ST_STBY  = 3'b010,
      RSCR_ST_TUNE  = 3'b011,
      RSCR_ST_RX    = 3'b100,
      RSCR_ST_NVM   = 3'b101
   } rscr_state_t;
endpackage

// ===== rtl/rscr_power_seq.sv
/*
 Power-up sequencer: counts out the power-up sequence after any reset and
 reports done or failed.
 Assumes start is a one-cycle pulse and por_ok is stable during the count.
*/
`timescale 1ns/1ps
`include "rscr_regs.svh"

module rscr_power_seq #(
   parameter int unsigned PUP_CYC = `RSCR_PUP_CYC_DEF
) (
   input  wire logic clk,     // Clock
   input  wire logic srst,    // Synchronous reset
   input  wire logic start,   // Restart the sequence
   input  wire logic por_ok,  // Power-on check passed
   output logic      done,    // Sequence passed, pulse
   output logic      failed   // Sequence failed, level
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        run;
      logic        done;
      logic        fail;
   } rscr_seq_t;

   rscr_seq_t s_q;
   rscr_seq_t s_d;

   // Count down, then check the power-on result once
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start) begin
         s_d.run  = 1'b1;
         s_d.fail = 1'b0;
         s_d.cnt  = 16'(PUP_CYC);
      end else if (s_q.run) begin
         if (s_q.cnt == 16'h0000) begin
            s_d.run  = 1'b0;
            s_d.done = por_ok;
            s_d.fail = !por_ok;
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end
   end

   // State register; reset starts a fresh sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q     <= '0;
         s_q.run <= 1'b1;
         s_q.cnt <= 16'(PUP_CYC);
      end else begin
         s_q <= s_d;
      end
   end

   assign done   = s_q.done;
   assign failed = s_q.fail;
endmodule

// ===== rtl/rscr_ctrl.sv
/*
 Receiver state control registers: function enables, operating state
 readback with state-change commands, and the software reset register.
 Assumes a synchronous byte register port decoded from the serial control
 interface, and por_ok from the analog power-on detector.
*/
`timescale 1ns/1ps
`include "rscr_regs.svh"

module rscr_ctrl #(
   parameter int unsigned PUP_CYC = `RSCR_PUP_CYC_DEF
) (
   input  wire logic        clk,          // 25 MHz clock
   input  wire logic        srst,         // Power-on reset, sync high
   input  wire logic        por_ok,       // Power-on check passed
   input  wire logic        reg_wr,       // Register write strobe
   input  wire logic        reg_rd,       // Register read strobe
   input  wire logic [6:0]  reg_addr,     // Register address
   input  wire logic [7:0]  reg_wdata,    // Write data
   output logic      [7:0]  reg_rdata,    // Read data, registered
   output logic             sleep_timer_halt,    // Stop sleep timer
   output logic             factory_test_enable, // Test mode enable
   output logic             fast_serial_enable,  // Up to 1 MHz serial
   output rscr_pkg::rscr_state_t state_readback, // Current state
   output logic             soft_reset_busy      // Power-up in progress
);
   import rscr_pkg::*;

   localparam logic [7:0] SETTLE = 8'(`RSCR_SETTLE_CYC);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  func;
      rscr_state_t st;
      rscr_state_t tgt;
      logic [7:0]  settle;
      logic        moving;
      logic        busy;
      logic [7:0]  rdata;
   } rscr_ctl_t;

   rscr_ctl_t c_q;
   rscr_ctl_t c_d;
   logic      seq_start;
   logic      seq_done;
   logic      seq_fail;

   // Command decode, shared by the write path and checks
   function automatic logic cmd_valid(input logic [4:0] cmd);
      case (cmd)
         `RSCR_CMD_NVM, `RSCR_CMD_STBY, `RSCR_CMD_TUNE,
         `RSCR_CMD_RX, `RSCR_CMD_SLEEP: cmd_valid = 1'b1;
         default: cmd_valid = 1'b0;
      endcase
   endfunction

   function automatic rscr_state_t cmd_state(input logic [4:0] cmd);
      case (cmd)
         `RSCR_CMD_NVM:   cmd_state = RSCR_ST_NVM;
         `RSCR_CMD_STBY:  cmd_state = RSCR_ST_STBY;
         `RSCR_CMD_TUNE:  cmd_state = RSCR_ST_TUNE;
         `RSCR_CMD_RX:    cmd_state = RSCR_ST_RX;
         default:         cmd_state = RSCR_ST_SLEEP;
      endcase
   endfunction

   wire wr_func  = reg_wr && reg_addr == `RSCR_OFS_FUNC;
   wire wr_opctl = reg_wr && reg_addr == `RSCR_OFS_OPCTL;
   wire wr_key   = reg_wr && reg_addr == `RSCR_OFS_SWRST && reg_wdata == `RSCR_SWRST_KEY;

   assign seq_start = wr_key;

   rscr_power_seq #(
      .PUP_CYC (PUP_CYC)
   ) u_seq (
      .clk    (clk),
      .srst   (srst),
      .start  (seq_start),
      .por_ok (por_ok),
      .done   (seq_done),
      .failed (seq_fail)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      c_d = c_q;
      // writable enables; reserved bits held at zero
      if (wr_func && !c_q.busy) begin
         c_d.func = reg_wdata & `RSCR_FUNC_MASK;
      end
      // only one-hot codes start a move; none reaches power-up
      if (wr_opctl && !c_q.busy && cmd_valid(reg_wdata[4:0])) begin
         c_d.tgt    = cmd_state(reg_wdata[4:0]);
         c_d.moving = 1'b1;
         c_d.settle = SETTLE;
      end else if (c_q.moving) begin
         // readback follows once the move has settled
         if (c_q.settle == 8'h01) begin
            c_d.st     = c_q.tgt;
            c_d.moving = 1'b0;
         end
         c_d.settle = c_q.settle - 8'h01;
      end
      // software reset acts as power-on: defaults restored
      if (wr_key) begin
         c_d.func   = `RSCR_FUNC_RESET;
         c_d.st     = RSCR_ST_PUP;
         c_d.moving = 1'b0;
         c_d.busy   = 1'b1;
      end else if (seq_done) begin
         c_d.st   = RSCR_ST_SLEEP;
         c_d.busy = 1'b0;
      end else if (seq_fail) begin
         c_d.st = RSCR_ST_PUP;
      end
      // state code in bits 7:5; reset register reads zero
      if (reg_rd) begin
         case (reg_addr)
            `RSCR_OFS_FUNC:  c_d.rdata = c_q.func;
            `RSCR_OFS_OPCTL: c_d.rdata = {c_q.st, 5'h00};
            default:         c_d.rdata = 8'h00;
         endcase
      end
   end

   // Register update; reset enters power-up until the sequence passes
   always_ff @(posedge clk) begin
      if (srst) begin
         c_q      <= '0;
         c_q.st   <= RSCR_ST_PUP;
         c_q.tgt  <= RSCR_ST_SLEEP;
         c_q.busy <= 1'b1;
      end else begin
         c_q <= c_d;
      end
   end

   assign reg_rdata           = c_q.rdata;
   assign sleep_timer_halt    = c_q.func[`RSCR_BIT_TIMER_HALT];
   assign factory_test_enable = c_q.func[`RSCR_BIT_TEST_EN];
   assign fast_serial_enable  = c_q.func[`RSCR_BIT_FAST_SER];
   assign state_readback      = c_q.st;
   assign soft_reset_busy     = c_q.busy;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_no_pup_cmd: assert property (@(posedge clk) disable iff (srst)
      (c_q.st != RSCR_ST_PUP && !wr_key) |=> c_q.st != RSCR_ST_PUP)
      else $error("power-up entered without reset");
   a_bad_cmd_ign: assert property (@(posedge clk) disable iff (srst)
      (wr_opctl && !cmd_valid(reg_wdata[4:0]) && !c_q.moving && !wr_key && !seq_done
       && !seq_fail) |=> $stable(c_q.st))
      else $error("invalid command changed state");
   a_rx_move: assert property (@(posedge clk) disable iff (srst)
      (wr_opctl && !c_q.busy && reg_wdata[4:0] == `RSCR_CMD_RX && !wr_key)
      |=> (c_q.tgt == RSCR_ST_RX))
      else $error("receive command not taken");
   a_key_reset: assert property (@(posedge clk) disable iff (srst)
      wr_key |=> (c_q.st == RSCR_ST_PUP && c_q.func == 8'h00 && c_q.busy))
      else $error("software reset not applied");
   a_nonkey_ign: assert property (@(posedge clk) disable iff (srst)
      (reg_wr && reg_addr == `RSCR_OFS_SWRST && !wr_key && !c_q.busy) |=> !c_q.busy)
      else $error("non-key write reset the device");
   a_sleep_done: assert property (@(posedge clk) disable iff (srst)
      (seq_done && !wr_key) |=> (c_q.st == RSCR_ST_SLEEP && !c_q.busy))
      else $error("power-up did not end in sleep");
   a_fail_pup: assert property (@(posedge clk) disable iff (srst)
      (seq_fail && !wr_key) |=> c_q.st == RSCR_ST_PUP)
      else $error("failed power-up left power-up state");
   a_func_write: assert property (@(posedge clk) disable iff (srst)
      (wr_func && !c_q.busy && !wr_key)
      |=> fast_serial_enable == $past(reg_wdata[2]))
      else $error("fast serial bit not written");
   a_read_state: assert property (@(posedge clk) disable iff (srst)
      (reg_rd && reg_addr == `RSCR_OFS_OPCTL) |=> reg_rdata[7:5] == $past(c_q.st))
      else $error("state readback wrong");
   a_settle_wait: assert property (@(posedge clk) disable iff (srst)
      (c_q.moving && c_q.settle > 8'h01 && !wr_key && !seq_done && !seq_fail)
      |=> $stable(c_q.st))
      else $error("readback changed before settling");
   // The last settle cycle must hand the target over, unless a new command restarts it or a software reset overrides it
   a_settle_end: assert property (@(posedge clk) disable iff (srst)
      (c_q.moving && c_q.settle == 8'h01 && !wr_key && !seq_done && !seq_fail
       && !(wr_opctl && !c_q.busy && cmd_valid(reg_wdata[4:0])))
      |=> c_q.st == $past(c_q.tgt))
      else $error("readback did not follow settled move");
   a_halt_write: assert property (@(posedge clk) disable iff (srst)
      (wr_func && !c_q.busy && !wr_key)
      |=> sleep_timer_halt == $past(reg_wdata[6]))
      else $error("timer halt bit not written");
   a_test_write: assert property (@(posedge clk) disable iff (srst)
      (wr_func && !c_q.busy && !wr_key)
      |=> factory_test_enable == $past(reg_wdata[5]))
      else $error("factory test bit not written");
   a_sleep_cmd: assert property (@(posedge clk) disable iff (srst)
      (wr_opctl && !c_q.busy && reg_wdata[4:0] == `RSCR_CMD_SLEEP)
      |=> (c_q.tgt == RSCR_ST_SLEEP && c_q.moving))
      else $error("sleep command not taken");
   a_stby_cmd: assert property (@(posedge clk) disable iff (srst)
      (wr_opctl && !c_q.busy && reg_wdata[4:0] == `RSCR_CMD_STBY)
      |=> (c_q.tgt == RSCR_ST_STBY && c_q.moving))
      else $error("standby command not taken");
   a_nvm_cmd: assert property (@(posedge clk) disable iff (srst)
      (wr_opctl && !c_q.busy && reg_wdata[4:0] == `RSCR_CMD_NVM)
      |=> (c_q.tgt == RSCR_ST_NVM && c_q.moving))
      else $error("nonvolatile command not taken");
   a_tune_cmd: assert property (@(posedge clk) disable iff (srst)
      (wr_opctl && !c_q.busy && reg_wdata[4:0] == `RSCR_CMD_TUNE)
      |=> (c_q.tgt == RSCR_ST_TUNE && c_q.moving))
      else $error("tune command not taken");
endmodule

// ===== tb/rscr_host_model.sv
/*
 Host model: issues byte register writes and reads to the control block.
 Assumes the block samples strobes on the rising clock edge.
*/
`timescale 1ns/1ps

module rscr_host_model #(
   parameter int unsigned RST_WAIT = 200  // Post-reset pause, shortened
) (
   input  wire logic       clk,        // Clock
   output logic            reg_wr,     // Write strobe
   output logic            reg_rd,     // Read strobe
   output logic [6:0]      reg_addr,   // Address
   output logic [7:0]      reg_wdata,  // Write data
   input  wire logic [7:0] reg_rdata   // Read data
);
   // Idle bus from time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
   end

   // One-cycle write; data inverted after release so stale values never match
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask

   // One-cycle read; registered data is settled by the next falling edge
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   // quiet after reset; 10 ms is far too long to simulate, so scaled
   task automatic pause();
      repeat (RST_WAIT) @(negedge clk);
   endtask
endmodule

// ===== tb/tb_top.sv
/*
 Self-checking bench of the receiver state control registers.
 Assumes PUP_CYC of 8 and a 100-cycle state settle time.
*/
`timescale 1ns/1ps
`include "rscr_regs.svh"

module tb_top;
   import rscr_pkg::*;
   typedef struct packed {
      logic [4:0]  cmd;
      rscr_state_t exp;
   } rscr_row_t;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        por_ok = 1'b1;
   logic        reg_wr, reg_rd, halt, test_en, fast, busy;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rd_val;
   rscr_state_t st, prev;
   int          err_total = 0;
   int          num_checks = 0;
   int          cycles = 0;
   // Every command code, then refused patterns, then a move away from sleep
   rscr_row_t   rows [9] = '{'{5'h02, RSCR_ST_STBY}, '{5'h04, RSCR_ST_TUNE},
      '{5'h08, RSCR_ST_RX}, '{5'h01, RSCR_ST_NVM}, '{5'h10, RSCR_ST_SLEEP},
      '{5'h03, RSCR_ST_SLEEP}, '{5'h00, RSCR_ST_SLEEP}, '{5'h18, RSCR_ST_SLEEP},
      '{5'h08, RSCR_ST_RX}};

   always #20 clk = ~clk;

   rscr_ctrl #(.PUP_CYC(8)) dut (.clk(clk), .srst(srst), .por_ok(por_ok),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .sleep_timer_halt(halt), .factory_test_enable(test_en),
      .fast_serial_enable(fast), .state_readback(st), .soft_reset_busy(busy));

   rscr_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // ----------------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (err_total == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Hang guard; the whole run needs about 1400 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total++;
         conclude();
      end
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (10) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      chk(st, RSCR_ST_PUP);
      chk(busy, 8'h01);
      repeat (20) @(negedge clk);
      chk(st, RSCR_ST_SLEEP);
      // Old state must hold mid-settle, new state after it
      foreach (rows[i]) begin
         prev = st;
         host.wr(`RSCR_OFS_OPCTL, {3'h0, rows[i].cmd});
         repeat (50) @(negedge clk);
         chk(st, prev);
         repeat (60) @(negedge clk);
         chk(st, rows[i].exp);
         host.rd(`RSCR_OFS_OPCTL, rd_val);
         chk(rd_val, {rows[i].exp, 5'h00});
      end
      host.wr(`RSCR_OFS_FUNC, 8'h64);
      @(negedge clk);
      chk({halt, test_en, fast}, 8'h07);
      host.rd(`RSCR_OFS_FUNC, rd_val);
      chk(rd_val, 8'h64);
      host.rd(7'h50, rd_val);
      chk(rd_val, 8'h00);
      // Near-miss key must leave everything alone
      host.wr(`RSCR_OFS_SWRST, 8'hfe);
      @(negedge clk);
      chk(st, RSCR_ST_RX);
      chk({halt, test_en, fast}, 8'h07);
      host.wr(`RSCR_OFS_SWRST, `RSCR_SWRST_KEY);
      @(negedge clk);
      chk(st, RSCR_ST_PUP);
      chk({halt, test_en, fast}, 8'h00);
      host.pause();
      chk(st, RSCR_ST_SLEEP);
      chk(busy, 8'h00);
      // Failed power-on: stuck in power-up, commands refused
      por_ok = 1'b0;
      srst = 1'b1;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (30) @(negedge clk);
      chk(st, RSCR_ST_PUP);
      host.wr(`RSCR_OFS_OPCTL, 8'h08);
      repeat (110) @(negedge clk);
      chk(st, RSCR_ST_PUP);
      chk(busy, 8'h01);
      conclude();
   end
endmodule
